// ### bench/subsystem_model.sv
// Subsystem model that drives the hardware request lines.
module subsystem_model (
  input  wire logic       ref_clk,
  input  wire logic       active_low,
  input  wire logic       want_proc,
  input  wire logic [2:0] want_conn,
  input  wire logic       want_modem,
  output logic            proc_group_request,
  output logic            conn_request_a,
  output logic            conn_request_b,
  output logic            conn_request_c,
  output logic            modem_group_request
);
  timeunit 1ns;
  timeprecision 100ps;
  assign proc_group_request  = want_proc ^ active_low;
  assign conn_request_a      = want_conn[0] ^ active_low;
  assign conn_request_b      = want_conn[1] ^ active_low;
  assign conn_request_c      = want_conn[2] ^ active_low;
  assign modem_group_request = want_modem ^ active_low;
endmodule

// ### bench/testbench.sv
// Self-checking bench of the power resource group manager.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic req_polarity_low = 1'h0, proc_req_mask = 1'h0;
  logic conn_req_mask = 1'h0, modem_req_mask = 1'h0;
  logic ctl_valid = 1'h0, ctl_bcast = 1'h0, vs_valid = 1'h0;
  logic slow_clk_in = 1'h0, pulse_src_a = 1'h0, pulse_src_b = 1'h0;
  logic [1:0] ctl_kind = 2'h0;
  logic [3:0] ctl_addr = 4'h0;
  logic [5:0] ctl_data = 6'h00;
  logic [7:0] vs_code = 8'h00;
  logic want_proc = 1'h0, want_modem = 1'h0;
  logic [2:0] want_conn = 3'h0;
  logic proc_group_request, conn_request_a, conn_request_b;
  logic conn_request_c, modem_group_request, seq_busy_out;
  logic power_on_reset_out, always_on_slow_clock_out;
  logic gated_slow_clock_out, audio_slow_clock_out, pulse_out_a;
  logic pulse_out_b, external_enable_out_a, external_enable_out_b;
  logic system_enable_out;
  logic [2:0][1:0] group_state_out;
  logic [1:0] common_state_out;
  logic [pwr_pkg::NUM_RES-1:0][1:0] resource_mode_out;
  logic [pwr_pkg::NUM_RES-1:0][1:0] resource_category_attr;
  logic [pwr_pkg::NUM_RES-1:0][2:0] group_membership_attr;
  logic [7:0] voltage_code_out;
  int bad_count = 0;
  int comparisons = 0;

  power_resource_group_manager power_resource_group_manager_i (.*);
  subsystem_model subsystem_model_i (.active_low(req_polarity_low), .*);

  always #5 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic ctl(input logic [1:0] k, input logic [3:0] a,
                     input logic [5:0] d);
    @(posedge ref_clk);
    ctl_valid <= 1'h1;
    ctl_kind <= k;
    ctl_addr <= a;
    ctl_data <= d;
    @(posedge ref_clk);
    ctl_valid <= 1'h0;
  endtask

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (seq_busy_out !== lvl && n < 600) begin
      cyc(1);
      n++;
    end
    `CHK("seq_busy_out", lvl, seq_busy_out)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'h0;
    cyc(1);
    for (int i = 0; i < pwr_pkg::NUM_RES; i++) begin
      `CHK("category", pwr_pkg::RES_CAT[i], resource_category_attr[i])
      `CHK("membership", pwr_pkg::HW_FIXED[i] ? 3'h0 : 3'h7, group_membership_attr[i])
      `CHK("mode", (i == 1 || i == 2 || i == 6) ? 2'h1 : 2'h0, resource_mode_out[i])
    end
    `CHK("reset out", 1'h1, power_on_reset_out)
    $display("test reset values done");
    ctl(pwr_pkg::CK_MEMB, 4'h0, 6'h01);
    ctl(pwr_pkg::CK_MEMB, 4'h3, 6'h01);
    ctl(pwr_pkg::CK_TCFG, 4'h4, 6'h24);
    cyc(2);
    `CHK("fixed membership", 3'h0, group_membership_attr[0])
    `CHK("membership", 3'h1, group_membership_attr[3])
    $display("test membership done");
    @(posedge ref_clk);
    conn_req_mask <= 1'h1;
    want_conn <= 3'h2;
    cyc(4);
    `CHK("masked group", pwr_pkg::GS_OFF, group_state_out[1])
    @(posedge ref_clk);
    want_proc <= 1'h1;
    slow_clk_in <= 1'h1;
    pulse_src_a <= 1'h1;
    pulse_src_b <= 1'h1;
    cyc(3);
    `CHK("proc group", pwr_pkg::GS_ACTIVE, group_state_out[0])
    `CHK("gated clock off", 1'h0, gated_slow_clock_out)
    `CHK("always on clock", 1'h1, always_on_slow_clock_out)
    wait_busy(1'h1);
    wait_busy(1'h0);
    cyc(2);
    `CHK("regulator woken", 2'h1, resource_mode_out[3])
    `CHK("remapped ldo", pwr_pkg::MODE_FORCE, resource_mode_out[4])
    `CHK("reset released", 1'h0, power_on_reset_out)
    `CHK("gated clock on", 1'h1, gated_slow_clock_out)
    `CHK("audio clock on", 1'h1, audio_slow_clock_out)
    `CHK("pulse a on", 1'h1, pulse_out_a)
    `CHK("enable a", 1'h1, external_enable_out_a)
    `CHK("enable b", 1'h1, external_enable_out_b)
    `CHK("system enable", 1'h1, system_enable_out)
    `CHK("pulse b on", 1'h1, pulse_out_b)
    `CHK("modem idle", pwr_pkg::GS_OFF, group_state_out[2])
    $display("test wake sequence done");
    ctl(pwr_pkg::CK_GROUP, 4'h4, 6'h01);
    cyc(3);
    `CHK("modem sleep", pwr_pkg::GS_SLEEP, group_state_out[2])
    `CHK("common", pwr_pkg::GS_ACTIVE, common_state_out)
    $display("test arbitration done");
    @(posedge ref_clk);
    vs_valid <= 1'h1;
    vs_code <= 8'h5a;
    @(posedge ref_clk);
    vs_valid <= 1'h0;
    cyc(2);
    `CHK("voltage code", 8'h5a, voltage_code_out)
    $display("test voltage port done");
    wait_busy(1'h0);
    @(posedge ref_clk);
    ctl_bcast <= 1'h1;
    ctl(pwr_pkg::CK_STATE, 4'h4, 6'h00);
    ctl_bcast <= 1'h0;
    cyc(2);
    `CHK("bcast off", pwr_pkg::MODE_OFF, resource_mode_out[10])
    `CHK("enable a off", 1'h0, external_enable_out_a)
    `CHK("pulse b gated", 1'h0, pulse_out_b)
    `CHK("not in group", 2'h1, resource_mode_out[3])
    ctl(pwr_pkg::CK_STATE, 4'hA, 6'h02);
    cyc(2);
    `CHK("individual", 2'h1, resource_mode_out[10])
    `CHK("enable a on", 1'h1, external_enable_out_a)
    $display("test broadcast done");
    results();
  end
endmodule

// ### hdl/mode_mapper.sv
// State arbitration among owning groups and remap to a resource mode.
module mode_mapper (
  input  wire logic [2:0][1:0] group_state,
  input  wire logic      [1:0] common_state,
  input  wire logic      [2:0] membership,
  input  wire logic            hw_fixed,
  input  wire logic      [1:0] kind,
  input  wire logic      [5:0] tcfg,
  output logic           [1:0] arb_state,
  output logic           [1:0] mode
);

  always_comb begin
    arb_state = pwr_pkg::GS_OFF;
    // [RL22] Hardwired resources follow common.
    if (hw_fixed) begin
      arb_state = common_state;
    end else begin
      // [RL23] Most capable state wins.
      for (int g = 0; g < pwr_pkg::NUM_GRP; g++) begin
        if (membership[g]) begin
          arb_state = pwr_pkg::max_state(arb_state, group_state[g]);
        end
      end
    end
    // [RL7] Per-resource state remap.
    mode = pwr_pkg::map_mode(kind, tcfg, arb_state);
  end

endmodule

// ### hdl/power_resource_group_manager.sv
// Group state keeping, arbitration and transition sequencing of resources.
// What this block does
// [RL1] Three subsystem groups run independently, in any combination.
// [RL2] Triggering events start a sequence that sets every affected resource.
// [RL3] Resources answer to their own address and to group broadcasts.
// [RL4] Each resource not hardwired has a writable membership over one or more groups.
// [RL5] Each resource has a fixed, read-only category attribute.
// [RL6] Group states are kept; shared resources take an arbitrated state.
// [RL7] Group state to resource mode mapping is remappable per resource.
// [RL8] Power resources offer off, automatic and forced modes; the KIND_BIN ones (R_ENA, R_ENB, R_SEN) take only off and on.
// [RL9] Switching regulators offer off, automatic and forced pulse-width.
// [RL10] Bandgap offers off, accurate, low power and fast; fast only on wake.
// [RL11] Reset resource active drives the power-on reset output high.
// [RL12] Clock and pulse outputs are gated while their resource is off.
// [RL13] State register holds target and timing; config holds behaviour.
// [RL14] Software should write config registers and leave state registers.
// [RL15] Voltage registers are written only from the voltage-scaling port.
// [RL16] Broadcasts are interpreted per resource; individual access by id.
// [RL17] Four groups: processor, connectivity, modem and device-common.
// [RL18] The device-common group has no per-group bits of its own.
// [RL19] Software must unassign unused resources from default groups.
// [RL20] A sleep to active move wakes every resource of the group.
// [RL21] A per-resource transition config lets one resource act differently.
// [RL22] Some resources are hardwired to the common group, others assignable.
// [RL23] Conflicting group requests grant the most capable state.
// [RL24] Request lines: one processor, three ORed connectivity, one modem.
// [RL25] Requests are active high by default, polarity selectable, masked.
module power_resource_group_manager (
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  input  wire logic                           proc_group_request,
  input  wire logic                           conn_request_a,
  input  wire logic                           conn_request_b,
  input  wire logic                           conn_request_c,
  input  wire logic                           modem_group_request,
  input  wire logic                           req_polarity_low,
  input  wire logic                           proc_req_mask,
  input  wire logic                           conn_req_mask,
  input  wire logic                           modem_req_mask,
  input  wire logic                           ctl_valid,
  input  wire logic                           ctl_bcast,
  input  wire logic                     [1:0] ctl_kind,
  input  wire logic                     [3:0] ctl_addr,
  input  wire logic                     [5:0] ctl_data,
  input  wire logic                           vs_valid,
  input  wire logic                     [7:0] vs_code,
  input  wire logic                           slow_clk_in,
  input  wire logic                           pulse_src_a,
  input  wire logic                           pulse_src_b,
  output logic                     [2:0][1:0] group_state_out,
  output logic                          [1:0] common_state_out,
  output logic [pwr_pkg::NUM_RES-1:0][1:0]    resource_mode_out,
  output logic [pwr_pkg::NUM_RES-1:0][1:0]    resource_category_attr,
  output logic [pwr_pkg::NUM_RES-1:0][2:0]    group_membership_attr,
  output logic                          [7:0] voltage_code_out,
  output logic                                seq_busy_out,
  output logic                                power_on_reset_out,
  output logic                                always_on_slow_clock_out,
  output logic                                gated_slow_clock_out,
  output logic                                audio_slow_clock_out,
  output logic                                pulse_out_a,
  output logic                                pulse_out_b,
  output logic                                external_enable_out_a,
  output logic                                external_enable_out_b,
  output logic                                system_enable_out
);

  localparam int N = pwr_pkg::NUM_RES;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h1,
    SEQ_WAIT  = 3'h2,
    SEQ_APPLY = 3'h4
  } seq_t;

  typedef struct packed {
    logic [2:0][1:0] grp_r;
    logic [2:0]      req_prev_r;
    logic            pend_r;
    logic            wake_r;
    seq_t            seq_r;
    logic            busy_r;
    logic [3:0]      idx_r;
    logic [8:0]      wait_r;
    logic [N-1:0][2:0] memb_r;
    logic [N-1:0][5:0] tcfg_r;
    logic [N-1:0][1:0] mode_r;
    logic [N-1:0][1:0] dly_r;
    logic [N-1:0][1:0] out_mode_r;
    logic [N-1:0][1:0] cat_r;
    logic [1:0]      common_r;
    logic [7:0]      vcode_r;
    logic            por_r;
    logic            aoclk_r;
    logic            gclk_r;
    logic            aclk_r;
    logic            pwa_r;
    logic            pwb_r;
    logic            ena_r;
    logic            enb_r;
    logic            sen_r;
  } mgr_t;

  mgr_t q;
  mgr_t d;

  logic [2:0]        req_lvl;
  logic [2:0]        req_en;
  logic [1:0]        common_st;
  logic [N-1:0][1:0] arb_st;
  logic [N-1:0][1:0] mapped;
  logic              apply;

  req_conditioner u_req (
    .ref_clk             (ref_clk),
    .reset               (reset),
    .proc_group_request  (proc_group_request),
    .conn_request_a      (conn_request_a),
    .conn_request_b      (conn_request_b),
    .conn_request_c      (conn_request_c),
    .modem_group_request (modem_group_request),
    .req_polarity_low    (req_polarity_low),
    .proc_req_mask       (proc_req_mask),
    .conn_req_mask       (conn_req_mask),
    .modem_req_mask      (modem_req_mask),
    .req_level           (req_lvl),
    .req_enable          (req_en)
  );

  // [RL17] [RL18] Common state derived, no own bits.
  assign common_st = pwr_pkg::max_state(pwr_pkg::max_state(q.grp_r[0],
                       q.grp_r[1]), q.grp_r[2]);

  // [RL6] One arbiter per resource.
  for (genvar i = 0; i < N; i++) begin : g_map
    mode_mapper u_map (
      .group_state  (q.grp_r),
      .common_state (common_st),
      .membership   (q.memb_r[i]),
      .hw_fixed     (pwr_pkg::HW_FIXED[i]),
      .kind         (pwr_pkg::RES_KIND[i]),
      .tcfg         (q.tcfg_r[i]),
      .arb_state    (arb_st[i]),
      .mode         (mapped[i])
    );
  end

  always_comb begin
    d = q;
    apply = 1'b0;
    // [RL2] Transition sequence walk.
    unique case (q.seq_r)
      SEQ_IDLE: begin
        if (q.pend_r) begin
          d.pend_r = 1'b0;
          d.idx_r  = 4'h0;
          d.wait_r = 9'(q.dly_r[0] * pwr_pkg::STEP_CYC);
          d.seq_r  = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (q.wait_r == 9'h000) begin
          d.seq_r = SEQ_APPLY;
        end else begin
          d.wait_r = q.wait_r - 9'h001;
        end
      end
      SEQ_APPLY: begin
        apply = 1'b1;
        if (q.idx_r == 4'(N - 1)) begin
          d.seq_r  = SEQ_IDLE;
          d.wake_r = 1'b0;
        end else begin
          d.idx_r  = q.idx_r + 4'h1;
          d.wait_r = 9'(q.dly_r[q.idx_r + 4'h1] * pwr_pkg::STEP_CYC);
          d.seq_r  = SEQ_WAIT;
        end
      end
    endcase
    d.busy_r = d.seq_r != SEQ_IDLE;
    // [RL1] Each group follows its own request.
    for (int g = 0; g < pwr_pkg::NUM_GRP; g++) begin
      if (req_en[g] && (req_lvl[g] != q.req_prev_r[g])) begin
        d.grp_r[g] = req_lvl[g] ? pwr_pkg::GS_ACTIVE : pwr_pkg::GS_SLEEP;
        d.pend_r   = 1'b1;
        if (req_lvl[g] && (q.grp_r[g] != pwr_pkg::GS_ACTIVE)) begin
          d.wake_r = 1'b1;
        end
      end
    end
    d.req_prev_r = req_lvl;
    if (ctl_valid) begin
      if (ctl_kind == pwr_pkg::CK_GROUP) begin
        for (int g = 0; g < pwr_pkg::NUM_GRP; g++) begin
          if (ctl_addr[g]) begin
            d.grp_r[g] = ctl_data[1:0];
            d.pend_r   = 1'b1;
            if (ctl_data[1:0] >= pwr_pkg::GS_ACTIVE) begin
              d.wake_r = 1'b1;
            end
          end
        end
      end else begin
        for (int i = 0; i < N; i++) begin
          // [RL3] Individual id or group broadcast select.
          if (ctl_bcast ? |({pwr_pkg::HW_FIXED[i], q.memb_r[i]} & ctl_addr)
                        : (ctl_addr == 4'(i))) begin
            unique case (ctl_kind)
              pwr_pkg::CK_STATE: begin
                // [RL16] Broadcast uses the resource's own config.
                if (ctl_bcast) begin
                  d.mode_r[i] = pwr_pkg::map_mode(pwr_pkg::RES_KIND[i],
                                  q.tcfg_r[i], ctl_data[1:0]);
                end else begin
                  // [RL13] Target mode and step timing.
                  d.mode_r[i] = pwr_pkg::clamp_mode(pwr_pkg::RES_KIND[i],
                                  ctl_data[1:0]);
                  d.dly_r[i]  = ctl_data[3:2];
                end
              end
              pwr_pkg::CK_MEMB: begin
                // [RL4] Membership writable unless hardwired.
                if (!pwr_pkg::HW_FIXED[i]) begin
                  d.memb_r[i] = ctl_data[2:0];
                end
              end
              default: begin
                // [RL21] Per-resource transition config.
                d.tcfg_r[i] = ctl_data;
              end
            endcase
          end
        end
      end
    end
    // [RL15] Voltage code only from scaling port.
    if (vs_valid) begin
      d.vcode_r = vs_code;
    end
    // [RL20] Sequencer step applies the mapped mode.
    if (apply) begin
      d.mode_r[q.idx_r] = mapped[q.idx_r];
    end
    d.common_r   = common_st;
    d.out_mode_r = q.mode_r;
    // [RL10] Fast bandgap only during a wake walk.
    if ((q.seq_r != SEQ_IDLE) && q.wake_r &&
        (q.mode_r[pwr_pkg::R_BG] != pwr_pkg::MODE_OFF)) begin
      d.out_mode_r[pwr_pkg::R_BG] = pwr_pkg::MODE_FAST;
    end
    // [RL11] Reset output follows reset resource.
    d.por_r   = q.mode_r[pwr_pkg::R_RST] != pwr_pkg::MODE_OFF;
    // [RL12] Gate clocks and pulse outputs.
    d.aoclk_r = slow_clk_in && (q.mode_r[pwr_pkg::R_AOCLK] != 2'h0);
    d.gclk_r  = slow_clk_in && (q.mode_r[pwr_pkg::R_GCLK] != 2'h0);
    d.aclk_r  = slow_clk_in && (q.mode_r[pwr_pkg::R_ACLK] != 2'h0);
    d.pwa_r   = pulse_src_a && (q.mode_r[pwr_pkg::R_PWA] != 2'h0);
    d.pwb_r   = pulse_src_b && (q.mode_r[pwr_pkg::R_PWB] != 2'h0);
    d.ena_r   = q.mode_r[pwr_pkg::R_ENA] != pwr_pkg::MODE_OFF;
    d.enb_r   = q.mode_r[pwr_pkg::R_ENB] != pwr_pkg::MODE_OFF;
    d.sen_r   = q.mode_r[pwr_pkg::R_SEN] != pwr_pkg::MODE_OFF;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q            <= '0;
      q.seq_r      <= SEQ_IDLE;
      q.memb_r     <= pwr_pkg::MEMB_RST;
      q.tcfg_r     <= pwr_pkg::TCFG_RST_VAL;
      q.mode_r     <= pwr_pkg::MODE_RST_VAL;
      q.out_mode_r <= pwr_pkg::MODE_RST_VAL;
      // [RL5] Category is a fixed constant.
      q.cat_r      <= pwr_pkg::RES_CAT;
      q.vcode_r    <= pwr_pkg::VCODE_RST;
      q.por_r      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign group_state_out          = q.grp_r;
  assign common_state_out         = q.common_r;
  assign resource_mode_out        = q.out_mode_r;
  assign resource_category_attr   = q.cat_r;
  assign group_membership_attr    = q.memb_r;
  assign voltage_code_out         = q.vcode_r;
  assign seq_busy_out             = q.busy_r;
  assign power_on_reset_out       = q.por_r;
  assign always_on_slow_clock_out = q.aoclk_r;
  assign gated_slow_clock_out     = q.gclk_r;
  assign audio_slow_clock_out     = q.aclk_r;
  assign pulse_out_a              = q.pwa_r;
  assign pulse_out_b              = q.pwb_r;
  assign external_enable_out_a    = q.ena_r;
  assign external_enable_out_b    = q.enb_r;
  assign system_enable_out        = q.sen_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_POR_RELEASE: assert property ( // [RL11]
    (q.mode_r[pwr_pkg::R_RST] == pwr_pkg::MODE_OFF) |=> !power_on_reset_out)
    else $error("Reset output high while reset resource released.");
  AST_GCLK_GATED: assert property ( // [RL12]
    (q.mode_r[pwr_pkg::R_GCLK] == pwr_pkg::MODE_OFF) |=> !gated_slow_clock_out)
    else $error("Gated clock delivered while its resource is off.");
  AST_VS_ONLY: assert property ( // [RL15]
    !vs_valid |=> $stable(voltage_code_out))
    else $error("Voltage code changed without a scaling port write.");
  AST_HW_MEMB: assert property ( // [RL22]
    q.memb_r[pwr_pkg::R_ANA] == pwr_pkg::M_NONE)
    else $error("Hardwired resource gained a group membership.");
  AST_CAT_FIXED: assert property ( // [RL5]
    resource_category_attr == pwr_pkg::RES_CAT)
    else $error("Resource category attribute changed.");
  AST_SEQ_START: assert property ( // [RL2]
    (q.seq_r == SEQ_IDLE && q.pend_r) |=> (q.seq_r == SEQ_WAIT) ##1 seq_busy_out)
    else $error("Pending trigger did not start the sequence.");
  AST_APPLY_MAP: assert property ( // [RL7]
    (q.seq_r == SEQ_APPLY) |=> (q.mode_r[$past(q.idx_r)] ==
                                $past(mapped[q.idx_r])))
    else $error("Sequencer step did not apply the mapped mode.");
  AST_ARB_MAX: assert property ( // [RL23]
    (q.memb_r[pwr_pkg::R_SMPS][pwr_pkg::G_PROC] &&
     q.grp_r[pwr_pkg::G_PROC] == pwr_pkg::GS_ACTIVE) |->
    (arb_st[pwr_pkg::R_SMPS] == pwr_pkg::GS_ACTIVE))
    else $error("Shared resource not granted the most capable state.");
  AST_PROC_ACTIVE: assert property ( // [RL25]
    ($rose(proc_group_request) && !req_polarity_low && !proc_req_mask)
    ##1 (proc_group_request && !ctl_valid && !req_polarity_low &&
         !proc_req_mask) [*2]
    |=> (group_state_out[pwr_pkg::G_PROC] == pwr_pkg::GS_ACTIVE))
    else $error("Processor request did not make its group active.");
  AST_BG_FAST: assert property ( // [RL10]
    (resource_mode_out[pwr_pkg::R_BG] == pwr_pkg::MODE_FAST) |->
    $past(q.wake_r))
    else $error("Bandgap in fast mode outside a wake sequence.");
  AST_SMPS_LEGAL: assert property ( // [RL9]
    resource_mode_out[pwr_pkg::R_SMPS] != pwr_pkg::MODE_FAST)
    else $error("Switching regulator in an illegal mode.");
endmodule

// ### hdl/pwr_pkg.sv
// Shared constants, resource tables and mode helpers of the power manager.
package pwr_pkg;

  localparam int NUM_GRP = 3;
  localparam int NUM_RES = 15;

  localparam int G_PROC  = 0;
  localparam int G_CONN  = 1;
  localparam int G_MODEM = 2;

  localparam logic [1:0] GS_OFF    = 2'h0;
  localparam logic [1:0] GS_SLEEP  = 2'h1;
  localparam logic [1:0] GS_ACTIVE = 2'h2;

  localparam logic [1:0] CAT_POWER = 2'h0;
  localparam logic [1:0] CAT_REF   = 2'h1;
  localparam logic [1:0] CAT_RESET = 2'h2;
  localparam logic [1:0] CAT_COMP  = 2'h3;

  localparam logic [1:0] KIND_LDO  = 2'h0;
  localparam logic [1:0] KIND_SMPS = 2'h1;
  localparam logic [1:0] KIND_BG   = 2'h2;
  localparam logic [1:0] KIND_BIN  = 2'h3;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_ON    = 2'h1;
  localparam logic [1:0] MODE_FORCE = 2'h2;
  localparam logic [1:0] MODE_FAST  = 2'h3;

  localparam logic [1:0] CK_STATE = 2'h0;
  localparam logic [1:0] CK_MEMB  = 2'h1;
  localparam logic [1:0] CK_TCFG  = 2'h2;
  localparam logic [1:0] CK_GROUP = 2'h3;

  localparam int R_ANA   = 0;
  localparam int R_AON   = 1;
  localparam int R_AOCLK = 2;
  localparam int R_SMPS  = 3;
  localparam int R_LDO   = 4;
  localparam int R_BG    = 5;
  localparam int R_RST   = 6;
  localparam int R_CMP   = 7;
  localparam int R_GCLK  = 8;
  localparam int R_ACLK  = 9;
  localparam int R_ENA   = 10;
  localparam int R_ENB   = 11;
  localparam int R_SEN   = 12;
  localparam int R_PWA   = 13;
  localparam int R_PWB   = 14;

  localparam logic [NUM_RES-1:0][1:0] RES_CAT = {
    CAT_REF, CAT_REF, CAT_POWER, CAT_POWER, CAT_POWER, CAT_REF, CAT_REF,
    CAT_COMP, CAT_RESET, CAT_REF, CAT_POWER, CAT_POWER, CAT_REF,
    CAT_POWER, CAT_POWER};
  localparam logic [NUM_RES-1:0][1:0] RES_KIND = {
    KIND_BIN, KIND_BIN, KIND_BIN, KIND_BIN, KIND_BIN, KIND_BIN, KIND_BIN,
    KIND_BIN, KIND_BIN, KIND_BG, KIND_LDO, KIND_SMPS, KIND_BIN,
    KIND_LDO, KIND_LDO};
  localparam logic [NUM_RES-1:0] HW_FIXED = 15'h0067;

  localparam logic [2:0] M_ALL  = 3'h7;
  localparam logic [2:0] M_NONE = 3'h0;
  localparam logic [NUM_RES-1:0][2:0] MEMB_RST = {
    M_ALL, M_ALL, M_ALL, M_ALL, M_ALL, M_ALL, M_ALL, M_ALL, M_NONE,
    M_NONE, M_ALL, M_ALL, M_NONE, M_NONE, M_NONE};

  // Transition config holds {active, sleep, off} modes, two bits each.
  localparam logic [5:0] TCFG_DEF = 6'h14;
  localparam logic [5:0] TCFG_AON = 6'h15;
  localparam logic [5:0] TCFG_BG  = 6'h18;
  localparam logic [5:0] TCFG_RST = 6'h01;
  localparam logic [NUM_RES-1:0][5:0] TCFG_RST_VAL = {
    TCFG_DEF, TCFG_DEF, TCFG_DEF, TCFG_DEF, TCFG_DEF, TCFG_DEF, TCFG_DEF,
    TCFG_DEF, TCFG_RST, TCFG_BG, TCFG_DEF, TCFG_DEF, TCFG_AON, TCFG_AON,
    TCFG_DEF};
  localparam logic [NUM_RES-1:0][1:0] MODE_RST_VAL = {
    MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF, MODE_OFF,
    MODE_OFF, MODE_ON, MODE_OFF, MODE_OFF, MODE_OFF, MODE_ON, MODE_ON,
    MODE_OFF};

  localparam logic [7:0] VCODE_RST = 8'h00;

  localparam int CLK_NS   = 10;
  localparam int STEP_NS  = 1000;
  localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;

  function automatic logic [1:0] max_state(input logic [1:0] a,
                                           input logic [1:0] b);
    return (a > b) ? a : b;
  endfunction

  // [RL8] [RL9] Kind-wise mode clamp.
  function automatic logic [1:0] clamp_mode(input logic [1:0] kind,
                                            input logic [1:0] m);
    if (kind == KIND_BIN) begin
      return (m != MODE_OFF) ? MODE_ON : MODE_OFF;
    end
    return (m == MODE_FAST) ? MODE_ON : m;
  endfunction

  function automatic logic [1:0] map_mode(input logic [1:0] kind,
                                          input logic [5:0] tcfg,
                                          input logic [1:0] st);
    logic [1:0] s;
    s = (st > GS_ACTIVE) ? GS_ACTIVE : st;
    return clamp_mode(kind, tcfg[{s, 1'b0} +: 2]);
  endfunction

endpackage

// ### hdl/req_conditioner.sv
// Polarity and masking of the subsystem hardware request lines.
module req_conditioner (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       proc_group_request,
  input  wire logic       conn_request_a,
  input  wire logic       conn_request_b,
  input  wire logic       conn_request_c,
  input  wire logic       modem_group_request,
  input  wire logic       req_polarity_low,
  input  wire logic       proc_req_mask,
  input  wire logic       conn_req_mask,
  input  wire logic       modem_req_mask,
  output logic      [2:0] req_level,
  output logic      [2:0] req_enable
);

  typedef struct packed {
    logic [2:0] lvl_r;
    logic [2:0] en_r;
  } cond_t;

  cond_t q;
  cond_t d;

  always_comb begin
    d = q;
    // [RL25] Polarity and per-group masks.
    d.lvl_r[pwr_pkg::G_PROC]  = proc_group_request ^ req_polarity_low;
    // [RL24] Connectivity lines ORed.
    d.lvl_r[pwr_pkg::G_CONN]  = (conn_request_a ^ req_polarity_low) |
                                (conn_request_b ^ req_polarity_low) |
                                (conn_request_c ^ req_polarity_low);
    d.lvl_r[pwr_pkg::G_MODEM] = modem_group_request ^ req_polarity_low;
    d.en_r = ~{modem_req_mask, conn_req_mask, proc_req_mask};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign req_level  = q.lvl_r;
  assign req_enable = q.en_r;

endmodule
